// ### inc/scms_pkg.sv
// Purpose: Shared constants and types for the serial channel mode setup.
// Assumes: 100 MHz clock, plain register port with 16-bit data.
// Notes: Register indices are word indices on the plain port.
`default_nettype none
package scms_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_PRIO_LOW = 4'h0;
  localparam logic [3:0] REG_PRIO_HIGH = 4'h1;
  localparam logic [3:0] REG_FLAG_CLR = 4'h2;
  localparam logic [3:0] REG_MODE = 4'h3;
  localparam logic [3:0] REG_DATA = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;
  localparam logic [3:0] REG_STOP = 4'h6;
  localparam logic [3:0] REG_START = 4'h7;
  localparam logic [3:0] REG_PRESCALE = 4'h8;
  localparam logic [3:0] REG_UNIT_EN = 4'h9;
  localparam logic [3:0] REG_RXDATA = 4'hA;
  localparam int PRIO_BIT = 5;
  localparam int FE_CLR_BIT = 2;
  localparam int PE_CLR_BIT = 1;
  localparam int OV_CLR_BIT = 0;
  localparam int CKS_BIT = 15;
  localparam int CCS_BIT = 14;
  localparam int MODE_HI_BIT = 2;
  localparam int MODE_LO_BIT = 1;
  localparam int IRQ_SRC_BIT = 0;
  localparam int DIV_MSB = 15;
  localparam int DIV_LSB = 9;
  localparam int ST_OVF_BIT = 0;
  localparam int ST_PEF_BIT = 1;
  localparam int ST_FEF_BIT = 2;
  localparam int ST_BFF_BIT = 5;
  localparam int ST_TSF_BIT = 6;
  localparam logic [15:0] MODE_RESET = 16'h0020;
  localparam logic [7:0] PRIO_RESET = 8'hFF;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic [7:0] PRS_RESET = 8'h00;
  localparam int FIFO_DEPTH = 8;
  localparam int DATA_W = 8;
  localparam int BIT_COUNT = 8;
  typedef enum logic [1:0] {
    SCMS_MODE_SYNC,
    SCMS_MODE_ASYNC,
    SCMS_MODE_TWO_WIRE,
    SCMS_MODE_BAD
  } scms_mode_t;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } scms_bus_t;
  typedef struct packed {
    logic sclk_o;
    logic sclk_oe;
    logic sdo;
  } scms_pins_t;
endpackage
`default_nettype wire

// ### rtl/scms_channel.sv
// Purpose: Mode setup, clocking and flag clearing of one serial channel.
// Assumes: Plain register port; strobes one cycle; read data next cycle.
// Notes: Clock selection is done with enables in one clock domain.
//
// Overview of operation
// - Priority level is {high reg bit 5, low reg bit 5}; 00 highest.
// - Writing 1 to clear-trigger bit 2 clears the framing error flag.
// - Writing 1 to clear-trigger bit 1 clears the parity error flag.
// - Writing 1 to clear-trigger bit 0 clears the overrun error flag.
// - Mode bit 15 picks prescaler output zero or one as operating clock.
// - Edge detection runs from the selected operating clock.
// - Mode bit 14 picks divided clock or serial clock pin (slave).
// - Shift, output, transfer-end interrupt and error-set logic use transfer clock; control logic follows bus writes.
// - Internal transfer clock divides operating clock by 2(N+1), N = data bits 15:9.
// - Mode bits 2:1: 00 sync, 01 async, 10 two-wire; 11 forbidden.
// - Mode bit 0: 0 transfer-end interrupt, 1 buffer-empty interrupt.
// - With unit clock enable low, unit is in reset and ignores writes.
// - Writing 1 to the stop trigger clears running flag, halts transfer.
// - Prescaler zero is clock divided by 2 to the 4-bit select field.
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module scms_channel
  import scms_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire scms_bus_t bus,
  output logic [15:0] rdata,
  input wire logic sclk_i,
  input wire logic sdi,
  output scms_pins_t pins,
  output logic [1:0] irq_level,
  output logic irq_pulse,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [DATA_W-1:0] rx_data
);
  //////////////////////////////////////////////////////////////////////////
  logic unit_clock_enable_q;
  logic ureset;
  logic wr_ok;
  logic [7:0] prio_low_q;
  logic [7:0] prio_high_q;
  logic [15:0] mode_q;
  logic [15:0] data_q;
  logic [7:0] prs_q;
  logic chan_running_flag_q;
  logic framing_err_flag_q;
  logic parity_err_flag_q;
  logic overrun_err_flag_q;
  logic [15:0] rdata_q;
  scms_mode_t mode;

  function automatic logic wr_to(input scms_bus_t b, input logic [3:0] a);
    return b.wr && (b.addr == a);
  endfunction

  // Unit-level reset covers the channel registers below except tx_buf_q, the shift registers, the sclk_i synchronizer, rdata_q and the pin outputs.
  assign ureset = !unit_clock_enable_q;
  assign wr_ok = bus.wr && unit_clock_enable_q;
  assign mode = scms_mode_t'({mode_q[MODE_HI_BIT], mode_q[MODE_LO_BIT]});
  assign irq_level = {prio_high_q[PRIO_BIT], prio_low_q[PRIO_BIT]};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      unit_clock_enable_q <= 1'b0;
    end else if (wr_to(bus, REG_UNIT_EN)) begin
      unit_clock_enable_q <= bus.wdata[0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prio_low_q <= PRIO_RESET;
      prio_high_q <= PRIO_RESET;
      mode_q <= MODE_RESET;
      data_q <= DATA_RESET;
      prs_q <= PRS_RESET;
    end else if (ureset) begin
      prio_low_q <= PRIO_RESET;
      prio_high_q <= PRIO_RESET;
      mode_q <= MODE_RESET;
      data_q <= DATA_RESET;
      prs_q <= PRS_RESET;
    end else if (wr_ok) begin
      if (bus.addr == REG_PRIO_LOW) begin
        prio_low_q <= bus.wdata[7:0];
      end
      if (bus.addr == REG_PRIO_HIGH) begin
        prio_high_q <= bus.wdata[7:0];
      end
      if (bus.addr == REG_MODE) begin
        mode_q <= bus.wdata;
      end
      if (bus.addr == REG_DATA) begin
        data_q <= bus.wdata;
      end
      if (bus.addr == REG_PRESCALE) begin
        prs_q <= bus.wdata[7:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Prescaler: a free counter; output k ticks when low k bits roll over.
  logic [15:0] pre_cnt_q;
  logic ck0_tick;
  logic ck1_tick;
  logic mck_tick;

  function automatic logic pre_tick(input logic [15:0] c,
                                    input logic [3:0] sel);
    logic [15:0] m;
    m = (16'h0001 << sel) - 16'h0001;
    return (c & m) == m;
  endfunction

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_cnt_q <= '0;
    end else if (ureset) begin
      pre_cnt_q <= '0;
    end else begin
      pre_cnt_q <= pre_cnt_q + 16'h0001;
    end
  end

  assign ck0_tick = pre_tick(pre_cnt_q, prs_q[3:0]);
  assign ck1_tick = pre_tick(pre_cnt_q, prs_q[7:4]);
  assign mck_tick = mode_q[CKS_BIT] ? ck1_tick : ck0_tick;

  //////////////////////////////////////////////////////////////////////////
  // Transfer clock: divided operating clock or edges seen on the pin.
  logic [6:0] div_cnt_q;
  logic int_half;
  logic sclk_s1_q;
  logic sclk_s2_q;
  logic sclk_d_q;
  logic ext_rise;
  logic ext_fall;
  logic int_clk_q;
  logic shift_edge;
  logic drive_edge;
  logic ext_sel;

  assign ext_sel = mode_q[CCS_BIT];
  // One half period is (div+1) operating-clock ticks: rate is fmck/(2(div+1)).
  assign int_half = mck_tick && (div_cnt_q == data_q[DIV_MSB:DIV_LSB]);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt_q <= '0;
    end else if (ureset || !chan_running_flag_q || int_half) begin
      div_cnt_q <= '0;
    end else if (mck_tick) begin
      div_cnt_q <= div_cnt_q + 7'h01;
    end
  end

  // The pin is sampled on operating-clock ticks by the edge detector.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_s1_q <= 1'b1;
      sclk_s2_q <= 1'b1;
      sclk_d_q <= 1'b1;
    end else begin
      sclk_s1_q <= sclk_i;
      sclk_s2_q <= sclk_s1_q;
      if (mck_tick) begin
        sclk_d_q <= sclk_s2_q;
      end
    end
  end

  assign ext_rise = mck_tick && sclk_s2_q && !sclk_d_q;
  assign ext_fall = mck_tick && !sclk_s2_q && sclk_d_q;

  //////////////////////////////////////////////////////////////////////////
  // Shift engine, run only by transfer-clock edges (idle-high clock).
  logic busy_q;
  logic [2:0] bit_q;
  logic [DATA_W-1:0] tx_sh_q;
  logic [DATA_W-1:0] rx_sh_q;
  logic tx_full_q;
  logic [DATA_W-1:0] tx_buf_q;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic last_bit;
  logic load;

  assign shift_edge = ext_sel ? ext_rise : (int_half && !int_clk_q);
  assign drive_edge = ext_sel ? ext_fall : (int_half && int_clk_q);
  assign last_bit = busy_q && shift_edge && (bit_q == 3'(BIT_COUNT-1));
  assign load = chan_running_flag_q && tx_full_q && (!busy_q || last_bit);
  assign fifo_in_valid = last_bit;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      int_clk_q <= 1'b1;
    end else if (ureset || !busy_q || ext_sel) begin
      int_clk_q <= 1'b1;
    end else if (int_half) begin
      int_clk_q <= !int_clk_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
      bit_q <= '0;
      tx_sh_q <= '0;
      rx_sh_q <= '0;
    end else if (ureset || !chan_running_flag_q) begin
      busy_q <= 1'b0;
      bit_q <= '0;
    end else if (load) begin
      busy_q <= 1'b1;
      bit_q <= '0;
      tx_sh_q <= tx_buf_q;
      if (last_bit) begin
        rx_sh_q <= {rx_sh_q[DATA_W-2:0], sdi};
      end
    end else if (busy_q) begin
      if (shift_edge) begin
        rx_sh_q <= {rx_sh_q[DATA_W-2:0], sdi};
        bit_q <= bit_q + 3'h1;
        busy_q <= !last_bit;
      end
      if (drive_edge && bit_q != '0) begin
        tx_sh_q <= {tx_sh_q[DATA_W-2:0], 1'b0};
      end
    end
  end

  // Transmit buffer: written through the low byte of the REG_RXDATA register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_full_q <= 1'b0;
      tx_buf_q <= '0;
    end else if (ureset) begin
      tx_full_q <= 1'b0;
    end else if (wr_ok && bus.addr == REG_RXDATA) begin
      tx_full_q <= 1'b1;
      tx_buf_q <= bus.wdata[DATA_W-1:0];
    end else if (load) begin
      tx_full_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Status, stop and start; hardware set beats software clear.
  logic clr_wr;

  assign clr_wr = wr_ok && bus.addr == REG_FLAG_CLR;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chan_running_flag_q <= 1'b0;
    end else if (ureset) begin
      chan_running_flag_q <= 1'b0;
    end else if (wr_ok && bus.addr == REG_STOP && bus.wdata[0]) begin
      chan_running_flag_q <= 1'b0;
    end else if (wr_ok && bus.addr == REG_START && bus.wdata[0]) begin
      chan_running_flag_q <= 1'b1;
    end
  end

  // Overrun: a received word found the receive FIFO full.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      overrun_err_flag_q <= 1'b0;
      parity_err_flag_q <= 1'b0;
      framing_err_flag_q <= 1'b0;
    end else if (ureset) begin
      overrun_err_flag_q <= 1'b0;
      parity_err_flag_q <= 1'b0;
      framing_err_flag_q <= 1'b0;
    end else begin
      if (last_bit && !fifo_in_ready) begin
        overrun_err_flag_q <= 1'b1;
      end else if (clr_wr && bus.wdata[OV_CLR_BIT]) begin
        overrun_err_flag_q <= 1'b0;
      end
      // Sync mode has no parity or framing; these only clear here.
      if (clr_wr && bus.wdata[PE_CLR_BIT]) begin
        parity_err_flag_q <= 1'b0;
      end
      if (clr_wr && bus.wdata[FE_CLR_BIT]) begin
        framing_err_flag_q <= 1'b0;
      end
    end
  end

  // Interrupt source: transfer end or buffer empty.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_pulse <= 1'b0;
    end else begin
      irq_pulse <= !ureset && (mode_q[IRQ_SRC_BIT] ? load : last_bit);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // The receive FIFO belongs to the unit, so it is held in reset with it.
  logic fifo_rst;
  assign fifo_rst = rst || ureset;

  scms_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(clk),
    .rst(fifo_rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data({rx_sh_q[DATA_W-2:0], sdi}),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pins <= '{sclk_o: 1'b1, sclk_oe: 1'b0, sdo: 1'b1};
    end else begin
      pins.sclk_o <= int_clk_q;
      pins.sclk_oe <= !ext_sel && mode == SCMS_MODE_SYNC && !ureset;
      // The last bit is held until the clock pin has risen, so the peer
      // never samples the idle level in place of it.
      pins.sdo <= busy_q ? tx_sh_q[DATA_W-1] :
                  (pins.sclk_o ? 1'b1 : pins.sdo);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= '0;
    end else if (bus.rd) begin
      case (bus.addr)
        REG_PRIO_LOW: rdata_q <= {8'h00, prio_low_q};
        REG_PRIO_HIGH: rdata_q <= {8'h00, prio_high_q};
        REG_FLAG_CLR: rdata_q <= 16'h0000;
        REG_MODE: rdata_q <= mode_q;
        REG_DATA: rdata_q <= data_q;
        REG_STATUS: begin
          rdata_q <= '0;
          rdata_q[ST_OVF_BIT] <= overrun_err_flag_q;
          rdata_q[ST_PEF_BIT] <= parity_err_flag_q;
          rdata_q[ST_FEF_BIT] <= framing_err_flag_q;
          rdata_q[ST_BFF_BIT] <= tx_full_q;
          rdata_q[ST_TSF_BIT] <= busy_q;
        end
        REG_START: rdata_q <= {15'h0000, chan_running_flag_q};
        REG_PRESCALE: rdata_q <= {8'h00, prs_q};
        REG_UNIT_EN: rdata_q <= {15'h0000, unit_clock_enable_q};
        default: rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign rdata = rdata_q;
endmodule // scms_channel
`default_nettype wire

// ### rtl/scms_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides.
// Assumes: One clock, asynchronous active-high reset.
// Notes: Full and empty are exact; no write when full, no read when empty.
`timescale 1ns/1ps
`default_nettype none
module scms_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wp_q;
  logic [PW-1:0] rp_q;
  logic [PW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rp_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == PW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == PW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule // scms_fifo
`default_nettype wire

// ### verification/scms_channel_sva.sv
// Purpose: Port-level assertions for the serial channel mode setup.
// Assumes: One clock; rst asynchronous, active high.
// Notes: Unit enable and mode are mirrored from bus writes.
`timescale 1ns/1ps
`default_nettype none
module scms_channel_sva
  import scms_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire scms_bus_t bus,
  input wire logic [15:0] rdata,
  input wire logic sclk_i,
  input wire logic sdi,
  input wire scms_pins_t pins,
  input wire logic [1:0] irq_level,
  input wire logic irq_pulse,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic [DATA_W-1:0] rx_data
);
  logic en_q;
  logic [15:0] mode_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) en_q <= 1'b0;
    else if (bus.wr && bus.addr == REG_UNIT_EN) en_q <= bus.wdata[0];
  end
  // The mirror falls back to reset while the unit is held off.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) mode_q <= MODE_RESET;
    else if (!en_q) mode_q <= MODE_RESET;
    else if (bus.wr && bus.addr == REG_MODE) mode_q <= bus.wdata;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  a_read_idle_zero: assert property (!$past(bus.rd) |-> rdata == 16'h0000)
    else $error("read data not zero outside its slot");
  a_clrreg_reads_zero: assert property (
    bus.rd && bus.addr == REG_FLAG_CLR |=> rdata == 16'h0000)
    else $error("flag clear register read not zero");
  a_prio_low_bit: assert property (
    en_q && bus.wr && bus.addr == REG_PRIO_LOW
    |=> irq_level[0] == $past(bus.wdata[PRIO_BIT]))
    else $error("priority level low bit wrong");
  a_prio_high_bit: assert property (
    en_q && bus.wr && bus.addr == REG_PRIO_HIGH
    |=> irq_level[1] == $past(bus.wdata[PRIO_BIT]))
    else $error("priority level high bit wrong");
  a_ext_clk_nodrive: assert property (
    mode_q[CCS_BIT] && $past(mode_q[CCS_BIT]) |-> !pins.sclk_oe)
    else $error("clock driven with external clock selected");
  a_mode_other_nodrive: assert property (
    mode_q[2:1] != 2'b00 && $past(mode_q[2:1]) != 2'b00 |-> !pins.sclk_oe)
    else $error("clock driven outside synchronous mode");
  a_unit_off_quiet: assert property (
    !en_q && !$past(en_q) |-> !pins.sclk_oe && !irq_pulse && !rx_valid)
    else $error("activity while unit clock is off");
  a_irq_one_cycle: assert property (irq_pulse |=> !irq_pulse)
    else $error("interrupt pulse longer than one cycle");
  a_stop_halts_clk: assert property (
    en_q && bus.wr && bus.addr == REG_STOP && bus.wdata[0]
    |=> ##3 pins.sclk_o [*8])
    else $error("serial clock moves after stop");
  a_rx_hold_stall: assert property (
    en_q && !(bus.wr && bus.addr == REG_UNIT_EN) && rx_valid && !rx_ready
    |=> rx_valid && $stable(rx_data))
    else $error("receive data changed while stalled");
  c_irq: cover property (irq_pulse);
  c_pop: cover property (rx_valid && rx_ready);
  c_stop: cover property (en_q && bus.wr && bus.addr == REG_STOP);
endmodule // scms_channel_sva
bind scms_channel scms_channel_sva scms_channel_sva_inst (
  .clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .sclk_i(sclk_i),
  .sdi(sdi), .pins(pins), .irq_level(irq_level), .irq_pulse(irq_pulse),
  .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data));
`default_nettype wire

// ### verification/scms_spi_peer.sv
// Purpose: Behavioural synchronous serial peer on the channel's pins.
// Assumes: Clock idles high; data changes on fall, sampled on rise.
// Notes: After restart the data line toggles, so stale bits never match.
`timescale 1ns/1ps
`default_nettype none
module scms_spi_peer (
  input wire logic sclk,
  input wire logic mosi,
  input wire logic restart,
  input wire logic [7:0] tx,
  output logic miso,
  output logic [7:0] rx,
  output logic [3:0] rcnt
);
  logic [7:0] sh;
  always @(negedge sclk or posedge restart) begin
    if (restart) begin
      sh <= tx;
      miso <= (miso === 1'b1) ? 1'b0 : 1'b1;
    end else begin
      miso <= sh[7];
      sh <= {sh[6:0], ~sh[0]};
    end
  end
  always @(posedge sclk or posedge restart) begin
    if (restart) rcnt <= 4'h0;
    else begin
      rx <= {rx[6:0], mosi};
      rcnt <= rcnt + 4'h1;
    end
  end
endmodule // scms_spi_peer
`default_nettype wire

// ### verification/tb_top.sv
// Purpose: Self-checking bench for the serial channel mode setup.
// Assumes: 100 MHz clock; bus driven right after rising edges.
// Notes: The serial clock line has a pull-up when not driven.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import scms_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  scms_bus_t bus = '0;
  logic rx_ready = 1'b0;
  logic peer_restart = 1'b0;
  logic [7:0] peer_tx = 8'h00;
  logic [15:0] rdata;
  scms_pins_t pins;
  logic [1:0] irq_level;
  logic irq_pulse, rx_valid, miso, sclk_w;
  logic [7:0] rx_data, peer_rx;
  logic [3:0] peer_rcnt;
  int err_total = 0, check_count = 0, low_run = 0, last_low = 0;
  int irq_cnt = 0, n0, n, pops;
  always #5 clk = ~clk;
  assign sclk_w = pins.sclk_oe ? pins.sclk_o : 1'b1;
  scms_channel scms_channel_inst (.clk(clk), .rst(rst), .bus(bus),
    .rdata(rdata), .sclk_i(sclk_w), .sdi(miso), .pins(pins),
    .irq_level(irq_level), .irq_pulse(irq_pulse), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data));
  scms_spi_peer scms_spi_peer_inst (.sclk(sclk_w), .mosi(pins.sdo),
    .restart(peer_restart), .tx(peer_tx), .miso(miso), .rx(peer_rx),
    .rcnt(peer_rcnt));
  // Length of the last low phase of the serial clock, in clock cycles.
  always @(posedge clk) begin
    if (irq_pulse === 1'b1) irq_cnt <= irq_cnt + 1;
    if (pins.sclk_o === 1'b0) low_run <= low_run + 1;
    else if (low_run != 0) begin
      last_low <= low_run;
      low_run <= 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic xfer(input logic [15:0] mode, input logic [7:0] prs,
                      input logic [7:0] dout, input logic [7:0] din);
    wr(REG_MODE, mode);
    wr(REG_PRESCALE, {8'h00, prs});
    wr(REG_START, 16'h0001);
    @(posedge clk);
    peer_tx <= din;
    peer_restart <= 1'b1;
    @(posedge clk);
    peer_restart <= 1'b0;
    n0 = irq_cnt;
    wr(REG_RXDATA, {8'h00, dout});
    for (n = 0; n < 500 && peer_rcnt != 4'h8; n++) @(posedge clk);
    if (n == 500) begin
      err_total++;
      complete_run();
    end
    repeat (4) @(posedge clk);
    chk({8'h00, peer_rx}, {8'h00, dout});
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(REG_MODE, MODE_RESET);
    rd(REG_PRIO_LOW, {8'h00, PRIO_RESET});
    wr(REG_MODE, 16'h0021);
    rd(REG_MODE, MODE_RESET);
    wr(REG_UNIT_EN, 16'h0001);
    $display("test reset_and_enable done");
    for (int c = 0; c < 4; c++) begin
      wr(REG_PRIO_LOW, c[0] ? 16'h00FF : 16'h00DF);
      wr(REG_PRIO_HIGH, c[1] ? 16'h00FF : 16'h00DF);
      #1;
      chk({14'h0, irq_level}, 16'(c));
    end
    rd(REG_FLAG_CLR, 16'h0000);
    rd(4'hF, 16'h0000);
    for (int m = 0; m < 3; m++) begin
      wr(REG_MODE, m == 2 ? 16'h4020 : 16'h0020 | 16'(2 << m));
      rd(REG_MODE, m == 2 ? 16'h4020 : 16'h0020 | 16'(2 << m));
    end
    $display("test priority_and_modes done");
    wr(REG_DATA, 16'h0200);
    for (int i = 0; i < 3; i++) begin
      xfer(16'h0020 | (i == 2 ? 16'h8000 : 16'h0000) | 16'(i == 1),
           8'h20 | 8'(i > 0), 8'hA5 ^ 8'(i), 8'h3C + 8'(i));
      chk(16'(last_low), 16'(2 << i));
      chk(16'(irq_cnt - n0), 16'h0001);
      @(negedge clk);
      chk({8'h00, rx_data}, {8'h00, 8'h3C + 8'(i)});
      @(posedge clk);
      rx_ready <= 1'b1;
      @(posedge clk);
      rx_ready <= 1'b0;
    end
    $display("test clocking_transfers done");
    for (int j = 0; j <= FIFO_DEPTH; j++) xfer(16'h0020, 8'h00, 8'(j), 8'(j));
    rd(REG_STATUS, 16'h0001 << ST_OVF_BIT);
    wr(REG_FLAG_CLR, 16'h0006);
    rd(REG_STATUS, 16'h0001 << ST_OVF_BIT);
    wr(REG_FLAG_CLR, 16'h0001);
    rd(REG_STATUS, 16'h0000);
    @(posedge clk);
    rx_ready <= 1'b1;
    pops = 0;
    repeat (12) begin
      @(negedge clk);
      if (rx_valid === 1'b1) pops++;
    end
    chk(16'(pops), 16'(FIFO_DEPTH));
    $display("test overrun_and_drain done");
    wr(REG_START, 16'h0001);
    rd(REG_START, 16'h0001);
    wr(REG_RXDATA, 16'h0055);
    repeat (6) @(posedge clk);
    wr(REG_STOP, 16'h0001);
    rd(REG_START, 16'h0000);
    repeat (12) @(posedge clk);
    $display("test stop done");
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
